// ===== logic/gpm_top.sv
/*
 power-mode state machine, low-charge and system-down alerts, charge
 integration and an ahb-lite register slave for a single-cell gauge.
 assumes measurements arrive on clk_in from adc logic, battery presence
 and the wake comparator come from pins, calibration and ocv logic answer
 with a one-cycle done pulse and an ocv valid level held until the next start.
*/
// How it works
// - low capacity below set level raises flag
// - capacity above clear level drops flag
// - low-battery pin mirrors flag when enabled
// - interrupt pin toggles on flag change
// - low voltage sets system-down, one toggle
// - voltage recovery clears system-down, one toggle
// - seven power modes, each own state
// - no battery: halted, powered, waiting
// - insertion: ocv, detected flag, profile pick
// - halted mode briefly wakes for commands
// - normal measures and decides mode changes
// - sleep needs enable and low current
// - offset calibration precedes sleep entry
// - sleep stops fast oscillator, periodic wake
// - sleep exits on current or wake
// - sleep-plus keeps both oscillators running
// - hibernate wakes on communication activity
// - battery removed: return to insert check
// - integrate sensed current into charge count
// - hibernate needs request, ocv, low current
// - sleep-plus entry by snooze, exit on traffic
`default_nettype none
`include "gpm_params.svh"

module gpm_top
    import gpm_pkg::*;
#(
    parameter int MEAS_CYCLES = `GPM_MEAS_CYCLES,
    parameter int SLEEP_CYCLES = `GPM_SLEEP_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // register bus
    input wire gpm_ahb_req_type ahb_in,
    output gpm_ahb_rsp_type ahb_out,
    // measurements and helpers on clk_in
    input wire gpm_meas_type meas_in,
    input wire logic comm_in,
    input wire logic ocv_valid_in,
    input wire logic cal_done_in,
    input wire logic [1:0] profile_in,
    // pins from outside
    input wire logic battery_present_in,
    input wire logic wake_current_in,
    // alert pins
    output logic low_battery_pin_out,
    output logic charge_int_pin_out,
    // power control
    output gpm_mode_type mode_out,
    output logic hfo_enable_out,
    output logic cpu_halt_out,
    output logic cal_start_out,
    output logic ocv_start_out,
    output logic [1:0] profile_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam gpm_state_type ST_RST = '{
        mode: GPM_BIC,
        ctrl: `GPM_CTRL_RST,
        soc_thr: `GPM_SOC_THR_RST,
        sd_thr: `GPM_SYSDN_THR_RST,
        cur_thr: `GPM_CUR_THR_RST,
        hfo_en: 1'b1,
        cpu_halt: 1'b1,
        rdy: 1'b1,
        default: '0
    };
    localparam logic [19:0] MEAS_RELOAD = 20'(MEAS_CYCLES - 1);
    localparam logic [19:0] SLEEP_RELOAD = 20'(SLEEP_CYCLES - 1);

    gpm_state_type q;
    gpm_state_type d;
    logic take;
    logic tick;
    logic measuring;
    logic bat;
    logic wake;
    logic low_cur;
    logic lc_n;
    logic sd_n;
    logic toggle;
    logic mapped;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        // pins pass two flops; only the second is read below
        d.bat_s1 = battery_present_in;
        d.bat_s2 = q.bat_s1;
        d.wake_s1 = wake_current_in;
        d.wake_s2 = q.wake_s1;
        bat = q.bat_s2;
        wake = q.wake_s2;
        low_cur = meas_in.average_current_value < q.cur_thr.sleep;
        d.cal_start = 1'b0;
        d.ocv_start = 1'b0;

        // measurement divider: slower period while idling in sleep modes
        measuring = (q.mode == GPM_NORMAL) || (q.mode == GPM_SLEEP) ||
                    (q.mode == GPM_SLEEPP);
        tick = (q.tick_cnt == 20'h0_0000);
        if (tick) begin
            d.tick_cnt = (q.mode == GPM_SLEEP || q.mode == GPM_SLEEPP) ?
                         SLEEP_RELOAD : MEAS_RELOAD;
        end else begin
            d.tick_cnt = q.tick_cnt - 20'h0_0001;
        end

        // alert flags with hysteresis, sampled on each measurement
        lc_n = q.low_charge_flag;
        sd_n = q.system_down_flag;
        toggle = 1'b0;
        if (tick && measuring) begin
            if (meas_in.remaining_capacity_value < q.soc_thr.set) begin
                lc_n = 1'b1;
            end else if (meas_in.remaining_capacity_value > q.soc_thr.clr) begin
                lc_n = 1'b0;
            end
            if (meas_in.voltage < q.sd_thr.set) begin
                sd_n = 1'b1;
            end else if (meas_in.voltage > q.sd_thr.clr) begin
                sd_n = 1'b0;
            end
            // coincident events give one toggle, not two that cancel
            toggle = ((lc_n != q.low_charge_flag) && q.ctrl.lci_en) ||
                     (sd_n != q.system_down_flag);
            d.charge = q.charge + {{16{meas_in.sense_current[15]}},
                                   meas_in.sense_current};
        end
        d.low_charge_flag = lc_n;
        d.system_down_flag = sd_n;
        d.charge_int_pin = q.charge_int_pin ^ toggle;

        // power modes
        case (q.mode)
            GPM_BIC: begin
                if (bat) begin
                    d.mode = GPM_INIT;
                    d.ocv_start = 1'b1;
                end
            end
            GPM_INIT: begin
                if (ocv_valid_in) begin
                    d.mode = GPM_NORMAL;
                    d.battery_detected_flag = 1'b1;
                    d.profile = profile_in;
                end
            end
            GPM_NORMAL: begin
                if (q.ctrl.hib_req && ocv_valid_in &&
                    meas_in.average_current_value < q.cur_thr.hib) begin
                    d.mode = GPM_HIB;
                    d.ctrl.hib_req = 1'b0;
                end else if (q.ctrl.sleep_en && low_cur && !wake) begin
                    d.mode = GPM_CAL;
                    d.cal_start = 1'b1;
                end else if (q.ctrl.snooze_en && low_cur && !wake && !comm_in) begin
                    d.mode = GPM_SLEEPP;
                end
            end
            GPM_CAL: begin
                if (cal_done_in) begin
                    d.mode = GPM_SLEEP;
                end
            end
            GPM_SLEEP: begin
                if (meas_in.average_current_value > q.cur_thr.sleep || wake) begin
                    d.mode = GPM_NORMAL;
                end
            end
            GPM_SLEEPP: begin
                if (comm_in || wake ||
                    meas_in.average_current_value > q.cur_thr.sleep) begin
                    d.mode = GPM_NORMAL;
                end
            end
            GPM_HIB: begin
                if (comm_in) begin
                    d.mode = GPM_INIT;
                    d.ocv_start = 1'b1;
                end
            end
            default: begin
                d.mode = GPM_BIC;
            end
        endcase
        if (!bat && q.mode != GPM_BIC) begin
            d.mode = GPM_BIC;
            d.battery_detected_flag = 1'b0;
            d.ocv_start = 1'b0;
            d.cal_start = 1'b0;
        end
        // fast oscillator off only in sleep and hibernate
        d.hfo_en = !(d.mode == GPM_SLEEP || d.mode == GPM_HIB);
        // halted while waiting for a battery, one awake cycle per command
        d.cpu_halt = (d.mode == GPM_BIC) &&
                     !(q.mode == GPM_BIC && comm_in);

        // register bus: writes land in the data phase
        take = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
        if (q.wr_pend) begin
            case (q.waddr)
                `GPM_OFF_CTRL: d.ctrl = ahb_in.hwdata[`GPM_CTRL_WIDTH-1:0];
                `GPM_OFF_SOC_THR: d.soc_thr = ahb_in.hwdata;
                `GPM_OFF_SYSDN_THR: d.sd_thr = ahb_in.hwdata;
                `GPM_OFF_CUR_THR: d.cur_thr = ahb_in.hwdata;
                default: begin
                end
            endcase
        end
        d.low_battery_pin = d.ctrl.lbp_en && d.low_charge_flag;
        mapped = (ahb_in.haddr[31:8] == 24'h00_0000);
        d.wr_pend = take && ahb_in.hwrite && mapped;
        d.waddr = ahb_in.haddr[7:0];
        d.rdata = 32'h0000_0000;
        // read mux looks at d so a write just before is seen at once
        if (take && !ahb_in.hwrite && mapped) begin
            case (ahb_in.haddr[7:0])
                `GPM_OFF_CTRL: d.rdata = {27'h000_0000, d.ctrl};
                `GPM_OFF_SOC_THR: d.rdata = d.soc_thr;
                `GPM_OFF_SYSDN_THR: d.rdata = d.sd_thr;
                `GPM_OFF_CUR_THR: d.rdata = d.cur_thr;
                `GPM_OFF_STATUS: d.rdata = {22'h00_0000, q.profile, q.hfo_en,
                                            q.mode, 1'b0, q.battery_detected_flag,
                                            q.system_down_flag, q.low_charge_flag};
                `GPM_OFF_CHARGE: d.rdata = q.charge;
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        d.rdy = 1'b1;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ahb_out.hreadyout = q.rdy;
    assign ahb_out.hresp = 1'b0;
    assign ahb_out.hrdata = q.rdata;
    assign low_battery_pin_out = q.low_battery_pin;
    assign charge_int_pin_out = q.charge_int_pin;
    assign mode_out = q.mode;
    assign hfo_enable_out = q.hfo_en;
    assign cpu_halt_out = q.cpu_halt;
    assign cal_start_out = q.cal_start;
    assign ocv_start_out = q.ocv_start;
    assign profile_out = q.profile;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence seq_meas;
        tick && measuring;
    endsequence

    sequence seq_insert;
        q.mode == GPM_BIC && bat;
    endsequence

    sequence seq_init_done;
        q.mode == GPM_INIT && ocv_valid_in && bat;
    endsequence

    AST_LC_SET: assert property (
        seq_meas and (meas_in.remaining_capacity_value < q.soc_thr.set)
        |=> q.low_charge_flag)
        else $error("low charge flag not set");

    AST_LC_CLR: assert property (
        seq_meas and (meas_in.remaining_capacity_value > q.soc_thr.clr) and
        !(meas_in.remaining_capacity_value < q.soc_thr.set)
        |=> !q.low_charge_flag)
        else $error("low charge flag not cleared");

    AST_LBP_PIN: assert property (
        $changed(q.low_charge_flag) && q.ctrl.lbp_en && $past(q.ctrl.lbp_en)
        |-> low_battery_pin_out == q.low_charge_flag)
        else $error("low battery pin does not follow flag");

    AST_LC_INT: assert property (
        $changed(q.low_charge_flag) && $past(q.ctrl.lci_en)
        |-> $changed(charge_int_pin_out))
        else $error("interrupt pin missed low charge change");

    AST_SD_SET: assert property (
        seq_meas and (meas_in.voltage < q.sd_thr.set) and !q.system_down_flag
        |=> q.system_down_flag && $changed(charge_int_pin_out)
        ##1 $stable(charge_int_pin_out) || $changed(q.low_charge_flag))
        else $error("system down set without single toggle");

    AST_SD_CLR: assert property (
        seq_meas and (meas_in.voltage > q.sd_thr.clr) and
        !(meas_in.voltage < q.sd_thr.set) and q.system_down_flag
        |=> !q.system_down_flag && $changed(charge_int_pin_out))
        else $error("system down clear without toggle");

    AST_INSERT: assert property (
        seq_insert |=> q.mode == GPM_INIT && ocv_start_out ##1 !ocv_start_out)
        else $error("insertion did not start ocv");

    AST_DETECT: assert property (
        seq_init_done |=> q.mode == GPM_NORMAL && q.battery_detected_flag)
        else $error("battery detected flag not set");

    AST_CAL_FIRST: assert property (
        q.mode == GPM_SLEEP && $past(q.mode) != GPM_SLEEP
        |-> $past(q.mode) == GPM_CAL)
        else $error("sleep entered without calibration");

    AST_SLEEP_HFO: assert property (
        q.mode == GPM_SLEEP |-> !hfo_enable_out)
        else $error("fast oscillator running in sleep");

    AST_SLPP_COMM: assert property (
        q.mode == GPM_SLEEPP && comm_in && bat |=> q.mode == GPM_NORMAL)
        else $error("traffic did not end sleep plus");

    AST_REMOVE: assert property (
        !bat && q.mode != GPM_BIC |=> q.mode == GPM_BIC && cpu_halt_out
        && !q.battery_detected_flag)
        else $error("battery removal not handled");

    AST_HALT_BIC: assert property (
        q.mode == GPM_BIC && $past(q.mode) == GPM_BIC && !$past(comm_in)
        |-> cpu_halt_out)
        else $error("processor awake while waiting for battery");

    AST_CAL_ENTRY: assert property (
        q.mode == GPM_CAL && $past(q.mode) == GPM_NORMAL
        |-> $past(q.ctrl.sleep_en) && cal_start_out)
        else $error("calibration entered without sleep enable");

    AST_SLPP_HFO: assert property (
        q.mode == GPM_SLEEPP |-> hfo_enable_out)
        else $error("fast oscillator stopped in sleep plus");

    AST_HIB_WAKE: assert property (
        q.mode == GPM_HIB && comm_in && bat |=> q.mode == GPM_INIT && ocv_start_out)
        else $error("traffic did not wake hibernate");

    AST_HIB_ENTRY: assert property (
        q.mode == GPM_HIB && $past(q.mode) == GPM_NORMAL
        |-> $past(q.ctrl.hib_req) && $past(ocv_valid_in))
        else $error("hibernate entered without request or ocv");

endmodule : gpm_top

`default_nettype wire

// ===== logic/gpm_params.svh
/*
 gauge power-mode block: register offsets, field positions, reset values
 and timing figures.
 assumes inclusion by bare name from the package and the top module.
*/
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GPM_OFF_CTRL 8'h00
`define GPM_OFF_SOC_THR 8'h04
`define GPM_OFF_SYSDN_THR 8'h08
`define GPM_OFF_CUR_THR 8'h0c
`define GPM_OFF_STATUS 8'h10
`define GPM_OFF_CHARGE 8'h14

// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define GPM_CTRL_SLEEP_EN 0
`define GPM_CTRL_SNOOZE_EN 1
`define GPM_CTRL_HIB_REQ 2
`define GPM_CTRL_LBP_EN 3
`define GPM_CTRL_LCI_EN 4
`define GPM_CTRL_WIDTH 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GPM_CTRL_RST 5'h00
`define GPM_SOC_THR_RST 32'h0096_0064
`define GPM_SYSDN_THR_RST 32'h0d48_0c1c
`define GPM_CUR_THR_RST 32'h0003_000a

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GPM_CLK_MHZ 40
`define GPM_MEAS_PERIOD_US 1000
`define GPM_SLEEP_PERIOD_US 20000
`define GPM_MEAS_CYCLES (`GPM_MEAS_PERIOD_US * `GPM_CLK_MHZ)
`define GPM_SLEEP_CYCLES (`GPM_SLEEP_PERIOD_US * `GPM_CLK_MHZ)

`endif

// ===== logic/gpm_pkg.sv
/*
 types of the gauge power-mode block: modes, bus carriers, state.
 assumes gpm_params.svh is on the include path.
*/
`default_nettype none
`include "gpm_params.svh"

package gpm_pkg;

    // ------------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GPM_BIC = 3'h0,
        GPM_INIT = 3'h1,
        GPM_NORMAL = 3'h2,
        GPM_CAL = 3'h3,
        GPM_SLEEP = 3'h4,
        GPM_SLEEPP = 3'h5,
        GPM_HIB = 3'h6
    } gpm_mode_type;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } gpm_ahb_req_type;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } gpm_ahb_rsp_type;

    typedef struct packed {
        logic [15:0] remaining_capacity_value;
        logic [15:0] voltage;
        logic [15:0] average_current_value;
        logic signed [15:0] sense_current;
    } gpm_meas_type;

    typedef struct packed {
        logic lci_en;
        logic lbp_en;
        logic hib_req;
        logic snooze_en;
        logic sleep_en;
    } gpm_ctrl_type;

    typedef struct packed {
        logic [15:0] clr;
        logic [15:0] set;
    } gpm_thr_type;

    typedef struct packed {
        logic [15:0] hib;
        logic [15:0] sleep;
    } gpm_cur_type;

    // ------------------------------------------------------------------
    // whole state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        gpm_mode_type mode;
        gpm_ctrl_type ctrl;
        gpm_thr_type soc_thr;
        gpm_thr_type sd_thr;
        gpm_cur_type cur_thr;
        logic low_charge_flag;
        logic system_down_flag;
        logic battery_detected_flag;
        logic low_battery_pin;
        logic charge_int_pin;
        logic hfo_en;
        logic cpu_halt;
        logic cal_start;
        logic ocv_start;
        logic [1:0] profile;
        logic [19:0] tick_cnt;
        logic [31:0] charge;
        logic wr_pend;
        logic [7:0] waddr;
        logic [31:0] rdata;
        logic rdy;
        logic bat_s1;
        logic bat_s2;
        logic wake_s1;
        logic wake_s2;
    } gpm_state_type;

endpackage : gpm_pkg

`default_nettype wire

// ===== test/gpm_helper_model.sv
/*
 model of the ocv and coulomb-counter calibration logic beside the gauge.
 assumes start pulses on clk_in; answers after one cycle or, with slow_in,
 after DELAY cycles.
*/
`default_nettype none

module gpm_helper_model #(
    parameter int DELAY = 6
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // requests from the gauge
    input wire logic ocv_start_in,
    input wire logic cal_start_in,
    input wire logic slow_in,
    // answers
    output logic ocv_valid_out,
    output logic cal_done_out,
    output logic [1:0] profile_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int ocv_cnt;
    int cal_cnt;
    logic ocv_valid_q;
    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    // profile fixed so the captured value can be predicted
    assign profile_out = 2'h2;
    // a stale valid is masked while the new request stands
    assign ocv_valid_out = ocv_valid_q && !ocv_start_in;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ocv_cnt <= 0;
            cal_cnt <= 0;
            ocv_valid_q <= 1'b0;
            cal_done_out <= 1'b0;
        end else begin
            cal_done_out <= 1'b0;
            // valid drops on a new request, so stale ocv is never seen
            if (ocv_start_in) begin
                ocv_valid_q <= 1'b0;
                ocv_cnt <= slow_in ? DELAY : 1;
            end else if (ocv_cnt == 1) begin
                ocv_valid_q <= 1'b1;
                ocv_cnt <= 0;
            end else if (ocv_cnt > 1) begin
                ocv_cnt <= ocv_cnt - 1;
            end
            if (cal_start_in) begin
                cal_cnt <= slow_in ? DELAY : 1;
            end else if (cal_cnt == 1) begin
                cal_done_out <= 1'b1;
                cal_cnt <= 0;
            end else if (cal_cnt > 1) begin
                cal_cnt <= cal_cnt - 1;
            end
        end
    end
endmodule : gpm_helper_model

`default_nettype wire

// ===== test/gpm_top_test.sv
/*
 self-checking bench of the gauge power-mode block over ahb-lite.
 assumes gpm_pkg, gpm_top and gpm_helper_model are compiled first.
*/
`default_nettype none
`include "gpm_params.svh"

module gpm_top_test
    import gpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in;
    logic reset_n_in;
    gpm_ahb_req_type req;
    gpm_ahb_req_type ahb_in;
    gpm_ahb_rsp_type ahb_out;
    gpm_meas_type meas;
    logic comm, bat, wake, slow, ocv_valid, cal_done, lbp, intp, hfo, halt, cal_s, ocv_s;
    logic [1:0] prof_in, prof_out;
    gpm_mode_type mode;
    logic [31:0] rd_q, rd;
    logic hr_q;
    int errors;
    int checks_done;
    localparam logic [15:0] CAP_T [7] = '{16'h64, 16'h32, 16'h78, 16'hc8, 16'hc8, 16'hc8, 16'hc8};
    localparam logic [15:0] VOLT_T [7] = '{16'he00, 16'he00, 16'he00, 16'he00, 16'hbb8, 16'hd48,
        16'hdac};
    // {int pin, low-battery pin, system down, low charge}
    localparam logic [3:0] EXP_T [7] = '{4'h0, 4'hd, 4'hd, 4'h0, 4'ha, 4'ha, 4'h0};
    // ----------------------------------------------------------------
    // design, helper model, bus sampling
    // ----------------------------------------------------------------
    gpm_top #(.MEAS_CYCLES(8), .SLEEP_CYCLES(32)) u_dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .ahb_in(ahb_in), .ahb_out(ahb_out), .meas_in(meas),
        .comm_in(comm), .ocv_valid_in(ocv_valid), .cal_done_in(cal_done), .profile_in(prof_in),
        .battery_present_in(bat), .wake_current_in(wake), .low_battery_pin_out(lbp),
        .charge_int_pin_out(intp), .mode_out(mode), .hfo_enable_out(hfo), .cpu_halt_out(halt),
        .cal_start_out(cal_s), .ocv_start_out(ocv_s), .profile_out(prof_out));
    gpm_helper_model u_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .ocv_start_in(ocv_s),
        .cal_start_in(cal_s), .slow_in(slow), .ocv_valid_out(ocv_valid),
        .cal_done_out(cal_done), .profile_out(prof_in));
    // single slave: its hreadyout is the bus hready
    always_comb begin
        ahb_in = req;
        ahb_in.hready = ahb_out.hreadyout;
    end
    // edge values captured before the flops move, avoiding a race
    always @(posedge clk_in) begin
        rd_q <= ahb_out.hrdata;
        hr_q <= ahb_out.hreadyout;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (hr_q !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            report_and_stop();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk_in);
        req.hsel <= 1'b1;
        req.htrans <= 2'h2;
        req.hwrite <= wr;
        req.haddr <= addr;
        req.hsize <= 3'h2;
        wait_ready();
        req.htrans <= 2'h0;
        req.hsel <= 1'b0;
        req.hwdata <= data;
        wait_ready();
        rd = rd_q;
    endtask : bus
    task automatic wait_mode(input gpm_mode_type m);
        int n;
        for (n = 0; n < 200 && mode !== m; n++) begin
            @(posedge clk_in);
            #1;
        end
        if (mode !== m) begin
            errors++;
            report_and_stop();
        end
    endtask : wait_mode
    task automatic pulse_comm();
        @(posedge clk_in);
        comm <= 1'b1;
        @(posedge clk_in);
        comm <= 1'b0;
    endtask : pulse_comm
    // ----------------------------------------------------------------
    // clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        errors = 0;
        checks_done = 0;
        req = '0;
        meas = '{16'h200, 16'he00, 16'h100, 16'sh0};
        {comm, bat, wake, slow} = 4'h0;
        reset_n_in = 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        bus(1'b0, `GPM_OFF_CTRL, 0); chk(rd, 32'h0);
        bus(1'b0, `GPM_OFF_SOC_THR, 0); chk(rd, `GPM_SOC_THR_RST);
        bus(1'b0, `GPM_OFF_SYSDN_THR, 0); chk(rd, `GPM_SYSDN_THR_RST);
        bus(1'b0, `GPM_OFF_CUR_THR, 0); chk(rd, `GPM_CUR_THR_RST);
        bus(1'b0, 32'h20, 0); chk(rd, 32'h0);
        bus(1'b0, 32'h104, 0); chk(rd, 32'h0);
        bus(1'b1, `GPM_OFF_STATUS, 32'hffff_ffff);
        bus(1'b0, `GPM_OFF_STATUS, 0); chk(rd, 32'h80);
        bus(1'b1, `GPM_OFF_CTRL, 32'h18);
        bus(1'b0, `GPM_OFF_CTRL, 0); chk(rd, 32'h18);
        chk(halt, 1'b1);
        pulse_comm();
        #1;
        chk(halt, 1'b0);
        @(posedge clk_in);
        #1;
        chk(halt, 1'b1);
        slow <= 1'b1;
        bat <= 1'b1;
        wait_mode(GPM_INIT);
        wait_mode(GPM_NORMAL);
        bus(1'b0, `GPM_OFF_STATUS, 0); chk(rd, 32'h2a4);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in);
            meas.remaining_capacity_value <= CAP_T[i];
            meas.voltage <= VOLT_T[i];
            repeat (20) @(posedge clk_in);
            bus(1'b0, `GPM_OFF_STATUS, 0);
            chk(rd[1:0], EXP_T[i][1:0]);
            chk({intp, lbp}, EXP_T[i][3:2]);
        end
        bus(1'b0, `GPM_OFF_CHARGE, 0); chk(rd, 32'h0);
        @(posedge clk_in);
        meas.sense_current <= 16'sh3;
        repeat (20) @(posedge clk_in);
        bus(1'b0, `GPM_OFF_CHARGE, 0);
        chk(32'(rd == 32'h6 || rd == 32'h9), 32'h1);
        @(posedge clk_in);
        meas.sense_current <= 16'sh0;
        meas.average_current_value <= 16'h5;
        bus(1'b1, `GPM_OFF_CTRL, 32'h19);
        wait_mode(GPM_CAL);
        wait_mode(GPM_SLEEP);
        chk(hfo, 1'b0);
        bus(1'b1, `GPM_OFF_CTRL, 32'h18);
        wake <= 1'b1;
        wait_mode(GPM_NORMAL);
        wake <= 1'b0;
        bus(1'b1, `GPM_OFF_CTRL, 32'h1a);
        wait_mode(GPM_SLEEPP);
        chk(hfo, 1'b1);
        bus(1'b1, `GPM_OFF_CTRL, 32'h18);
        pulse_comm();
        wait_mode(GPM_NORMAL);
        @(posedge clk_in);
        meas.average_current_value <= 16'h2;
        bus(1'b1, `GPM_OFF_CTRL, 32'h1c);
        wait_mode(GPM_HIB);
        bus(1'b0, `GPM_OFF_CTRL, 0); chk(rd, 32'h18);
        pulse_comm();
        wait_mode(GPM_INIT);
        wait_mode(GPM_NORMAL);
        bat <= 1'b0;
        wait_mode(GPM_BIC);
        bus(1'b0, `GPM_OFF_STATUS, 0); chk(rd[2], 1'b0);
        chk(halt, 1'b1);
        report_and_stop();
    end
endmodule : gpm_top_test

`default_nettype wire
